// ---- hdl/glf_flasher.sv ----
// Guard lamp row flasher with caution and fault alarm monitoring
`default_nettype none
module glf_flasher #(
	parameter int unsigned LAMPS       = glf_pkg::LAMP_COUNT,
	parameter int unsigned HALF_CYC    = glf_pkg::HALF_PERIOD_CYC,
	parameter int unsigned HOLD_HALVES = glf_pkg::HOLDOVER_HALVES
) (
	// Clock and reset
	input  wire logic               ref_clk_in,
	input  wire logic               sys_rst_in,
	// Vault contacts
	input  wire logic               activate_in,
	input  wire logic               caution_reset_in,
	input  wire logic               link_ok_in,
	// Failure reports
	input  wire logic [LAMPS-1:0]   lamp_fail_in,
	input  wire logic [LAMPS-1:0]   device_fail_in,
	input  wire logic [LAMPS-1:0]   xfmr_fail_in,
	input  wire logic [LAMPS-1:0]   device_link_lost_in,
	input  wire logic               io_module_fail_in,
	// Lamp drive
	output logic [LAMPS-1:0]        guard_lamp_out,
	output logic                    even_phase_out,
	output logic                    running_out,
	// Alarms and classification
	output logic                    caution_out,
	output logic                    fault_out,
	output logic [LAMPS-1:0]        component_fail_out,
	output logic [LAMPS-1:0]        comm_fail_out
);
	import glf_pkg::*;

	// Elaboration-time refusal of parameter values the logic cannot serve
	if (LAMPS < 2 || HALF_CYC < 1 || HOLD_HALVES < 1) begin : g_param_check
		$error("glf_flasher: unsupported parameter values");
	end

	localparam int unsigned DW = $clog2(HALF_CYC + 1);
	localparam int unsigned HW = $clog2(HOLD_HALVES + 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		glf_mode_type     mode;
		logic [DW-1:0]    div;
		logic [HW-1:0]    hold;
		logic             phase;
		logic             caution_latch;
		logic             fault;
		logic [LAMPS-1:0] lamps;
		logic [LAMPS-1:0] comp;
		logic [LAMPS-1:0] comm;
	} glf_state_type;

	glf_state_type state;
	glf_state_type next_state;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic adjacent_pair(input logic [LAMPS-1:0] v);
		logic r;
		r = 1'b0;
		for (int i = 0; i < LAMPS - 1; i++) begin
			r = r | (v[i] & v[i+1]);
		end
		return r;
	endfunction

	function automatic int unsigned ones(input logic [LAMPS-1:0] v);
		int unsigned n;
		n = 0;
		for (int i = 0; i < LAMPS; i++) begin
			n = n + int'(v[i]);
		end
		return n;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic             half_tick;
		logic [LAMPS-1:0] comp_now;
		logic [LAMPS-1:0] set_mask;
		logic             any_fail;
		next_state = state;
		set_mask   = '0;
		half_tick  = (state.div == DW'(HALF_CYC - 1));
		comp_now   = lamp_fail_in | device_fail_in | xfmr_fail_in;
		any_fail   = (|lamp_fail_in) | (|device_fail_in) | io_module_fail_in;
		next_state.comp = comp_now;
		next_state.comm = device_link_lost_in;
		// Fault follows the live lamp failure picture only
		next_state.fault = adjacent_pair(lamp_fail_in) | (ones(lamp_fail_in) >= 3);
		// Caution latches; reset contact clears unless a lamp, device or I/O module failure is present, which sets it
		if (any_fail) begin
			next_state.caution_latch = 1'b1;
		end else if (caution_reset_in) begin
			next_state.caution_latch = 1'b0;
		end
		// Mode control
		case (state.mode)
			GLF_IDLE: begin
				if (activate_in && link_ok_in) begin
					next_state.mode  = GLF_RUN;
					next_state.div   = '0;
					next_state.phase = 1'b0;
				end
			end
			GLF_RUN: begin
				if (!link_ok_in) begin
					next_state.mode = GLF_HOLD;
					next_state.hold = '0;
				end else if (!activate_in) begin
					next_state.mode = GLF_IDLE;
				end
			end
			GLF_HOLD: begin
				if (link_ok_in) begin
					next_state.mode = activate_in ? GLF_RUN : GLF_IDLE;
				end else if (half_tick && state.hold == HW'(HOLD_HALVES - 1)) begin
					next_state.mode = GLF_IDLE;
				end else if (half_tick) begin
					next_state.hold = state.hold + HW'(1);
				end
			end
			default: begin
				next_state.mode = GLF_IDLE;
			end
		endcase
		// One shared divider drives both sets, so skew is zero
		if (state.mode != GLF_IDLE) begin
			if (half_tick) begin
				next_state.div   = '0;
				next_state.phase = ~state.phase;
			end else begin
				next_state.div = state.div + DW'(1);
			end
		end
		for (int i = 0; i < LAMPS; i++) begin
			set_mask[i] = (i % 2 == 0) ? ~next_state.phase : next_state.phase;
		end
		if (next_state.mode == GLF_IDLE) begin
			next_state.lamps = '0;
		end else begin
			next_state.lamps = set_mask & ~device_fail_in;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			state <= '{mode: GLF_IDLE, default: '0};
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign guard_lamp_out     = state.lamps;
	assign even_phase_out     = ~state.phase;
	assign running_out        = (state.mode != GLF_IDLE);
	assign fault_out          = state.fault;
	assign caution_out        = state.caution_latch | state.fault;
	assign component_fail_out = state.comp;
	assign comm_fail_out      = state.comm;
endmodule
`default_nettype wire

// ---- hdl/glf_pkg.sv ----
// Package with constants and types for the guard lamp row flasher and monitor
`default_nettype none
package glf_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ           = 50_000_000;
	localparam int unsigned FLASH_PER_MIN    = 31;
	// Half of one flash cycle in clock cycles: 60 s / 31 / 2
	localparam int unsigned HALF_PERIOD_CYC  = (CLK_HZ * 60) / (FLASH_PER_MIN * 2);
	localparam int unsigned HOLDOVER_HOURS   = 8;
	localparam int unsigned HOLDOVER_HALVES  = (HOLDOVER_HOURS * 3600 * FLASH_PER_MIN * 2) / 60;
	localparam int unsigned LAMP_COUNT       = 8;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		GLF_IDLE,
		GLF_RUN,
		GLF_HOLD
	} glf_mode_type;
endpackage
`default_nettype wire

// ---- bench/glf_flasher_asserts.sv ----
// Checker for the guard lamp row flasher
`default_nettype none
module glf_flasher_asserts #(
	parameter int unsigned LAMPS = 8
) (
	input wire logic             ref_clk_in,
	input wire logic             sys_rst_in,
	input wire logic             activate_in,
	input wire logic             link_ok_in,
	input wire logic             io_module_fail_in,
	input wire logic [LAMPS-1:0] lamp_fail_in,
	input wire logic [LAMPS-1:0] device_fail_in,
	input wire logic [LAMPS-1:0] guard_lamp_out,
	input wire logic             even_phase_out,
	input wire logic             running_out,
	input wire logic             caution_out,
	input wire logic             fault_out
);
	localparam logic [LAMPS-1:0] EVEN = {(LAMPS/2){2'b01}};
	wire logic adj = |(lamp_fail_in & (lamp_fail_in >> 1));
	wire logic many = $countones(lamp_fail_in) >= 3;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_start; $rose(running_out) && even_phase_out; endsequence
	sequence s_held; running_out[*3]; endsequence
	a_fault_adjacent: assert property (adj |=> fault_out) else $error("no fault on pair");
	a_fault_count: assert property (many |=> fault_out) else $error("no fault on three");
	a_fault_clear: assert property (!adj && !many |=> !fault_out) else $error("fault stuck");
	a_caution_fault: assert property (fault_out |-> caution_out) else $error("caution off");
	a_caution_set: assert property (|lamp_fail_in || |device_fail_in || io_module_fail_in |=> caution_out)
		else $error("caution missed");
	a_run_start: assert property (!running_out && activate_in && link_ok_in |=> running_out && even_phase_out)
		else $error("no start");
	a_lamp_pattern: assert property (guard_lamp_out == (running_out ?
		(even_phase_out ? EVEN : ~EVEN) & ~$past(device_fail_in) : '0)) else $error("bad lamps");
	a_half_period: assert property (s_start ##1 s_held |-> even_phase_out ##1 !(even_phase_out && running_out))
		else $error("bad half period");
endmodule
bind glf_flasher glf_flasher_asserts #(.LAMPS(LAMPS)) chk_u (.*);
`default_nettype wire

// ---- bench/glf_vault_model.sv ----
// Vault master model driving the contacts
`default_nettype none
module glf_vault_model (
	input  wire logic clk_in,
	input  wire logic on_in,
	input  wire logic link_in,
	input  wire logic clear_in,
	output var logic  activate_out = 1'b0,
	output var logic  link_ok_out = 1'b1,
	output var logic  reset_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk_in) begin
		activate_out <= on_in;
		link_ok_out  <= link_in;
		reset_out    <= clear_in;
	end
endmodule
`default_nettype wire

// ---- bench/glf_flasher_tb_top.sv ----
// Bench for the guard lamp row flasher
`default_nettype none
module glf_flasher_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 0, rst = 1, on = 0, lnk = 1, clr = 0, io = 0, act, cr, lok, ev, run, cau, flt;
	logic [7:0] lf = 0, dv = 0, xf = 0, ll = 0, lam, cmp, cml;
	int         errors = 0, checks_done = 0, seed = 32'h1a79;
	always #10 clk = ~clk;
	glf_vault_model vm_u (.clk_in(clk), .on_in(on), .link_in(lnk), .clear_in(clr), .activate_out(act),
		.link_ok_out(lok), .reset_out(cr));
	glf_flasher #(.HALF_CYC(4), .HOLD_HALVES(3)) dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .activate_in(act),
		.caution_reset_in(cr), .link_ok_in(lok), .lamp_fail_in(lf), .device_fail_in(dv), .xfmr_fail_in(xf),
		.device_link_lost_in(ll), .io_module_fail_in(io), .guard_lamp_out(lam), .even_phase_out(ev),
		.running_out(run), .caution_out(cau), .fault_out(flt), .component_fail_out(cmp), .comm_fail_out(cml));
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic [7:0] exp_fault(logic [7:0] v);
		return {7'h0, |(v & (v >> 1)) || $countones(v) >= 3};
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#50000;
		errors++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		on <= 1;
		for (int i = 0; i < 10 && run !== 1; i++)
			tick(1);
		chk("lamps", 8'h55, lam);
		chk("even", 8'h1, {7'h0, ev});
		tick(4);
		chk("lamps", 8'haa, lam);
		chk("even", 8'h0, {7'h0, ev});
		for (int i = 0; i < 150; i++) begin
			@(posedge clk);
			lf <= i == 0 ? 8'h81 : i == 1 ? 8'h15 : 8'($random(seed) & $random(seed) & $random(seed));
			dv <= 8'($random(seed) & $random(seed) & $random(seed));
			xf <= 8'($random(seed));
			ll <= 8'($random(seed));
			io <= 4'($random(seed)) == 4'h0;
			tick(1);
			chk("fault", exp_fault(lf), {7'h0, flt});
			chk("component", lf | dv | xf, cmp);
			chk("comm", ll, cml);
			if (lf || dv || io)
				chk("caution", 8'h1, {7'h0, cau});
		end
		@(posedge clk);
		{lf, dv, xf, ll, io} <= '0;
		repeat (2) @(posedge clk);
		clr <= 1;
		@(posedge clk);
		clr <= 0;
		tick(3);
		chk("caution", 8'h0, {7'h0, cau});
		@(posedge clk);
		lf <= 8'h08;
		tick(1);
		chk("caution", 8'h1, {7'h0, cau});
		@(posedge clk);
		lf <= 8'h00;
		lnk <= 0;
		tick(6);
		chk("running", 8'h1, {7'h0, run});
		tick(18);
		chk("running", 8'h0, {7'h0, run});
		@(posedge clk);
		lnk <= 1;
		tick(4);
		chk("running", 8'h1, {7'h0, run});
		@(posedge clk);
		rst <= 1;
		lf <= 8'h03;
		tick(2);
		chk("reset", 8'h0, lam | {7'h0, flt});
		conclude();
	end
endmodule
`default_nettype wire
